// file: adc_result_readout_port.sv
`timescale 1ns/10ps
module adc_result_readout_port
   import readout_pkg::*;
(
   input wire logic sys_clk_i, // 100 MHz clock
   input wire logic resetn_i, // sync reset, active low
   input wire logic [NUM_CH*RESULT_W-1:0] results_i, // latched results, channel 0 lowest
   input wire logic [OSR_W-1:0] oversample_ratio_sel_i, // ratio select pins
   output logic [OSR_W-1:0] oversample_ratio_o, // synchronised ratio select
   input wire logic interface_select_i, // low parallel, high serial
   input wire logic cs_n_i, // chip select pin
   input wire logic rd_n_sclk_i, // read strobe or serial clock pin
   input wire logic [BUS_W-1:0] bus_i, // bus pin levels, unused
   output logic [BUS_W-1:0] bus_o, // bus pin drive value
   output logic [BUS_W-1:0] bus_oe_n_o // bus drive enable, low drives
);
   ////////////////////////////////////////////////////////////
   // three-stage pin synchronisers; first stage feeds only the second
   // reset loads idle pin levels, so no false strobe edge follows reset
   logic [SYNC_W-1:0] s1;
   logic [SYNC_W-1:0] s2;
   logic [SYNC_W-1:0] s3;
   wire [SYNC_W-1:0] pins_raw = {oversample_ratio_sel_i, interface_select_i, cs_n_i, rd_n_sclk_i};

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         s1 <= SYNC_IDLE;
         s2 <= SYNC_IDLE;
         s3 <= SYNC_IDLE;
      end else begin
         s1 <= pins_raw;
         s2 <= s1;
         s3 <= s2;
      end
   end

   ////////////////////////////////////////////////////////////
   // helper functions

   // a change counts once stages two and three agree
   function automatic logic settle(input logic a, input logic b, input logic old);
      return (a == b) ? a : old;
   endfunction

   // ascending channel order, wrapping after the last channel
   function automatic logic [CH_W-1:0] chan_after(input logic [CH_W-1:0] c);
      return (c == LAST_CH) ? '0 : c + 1'b1;
   endfunction

   // one channel's result out of the packed result word
   function automatic logic [RESULT_W-1:0] ch_result(input logic [NUM_CH*RESULT_W-1:0] rs, input logic [CH_W-1:0] c);
      return rs[int'(c)*RESULT_W +: RESULT_W];
   endfunction

   // one serial bit; position zero is the msb
   function automatic logic ser_bit(input logic [RESULT_W-1:0] r, input logic [BITPOS_W-1:0] p);
      return r[RESULT_W-1-int'(p)];
   endfunction

   ////////////////////////////////////////////////////////////
   // settled pin levels
   logic sel_ser;
   logic cs_n;
   logic rd_n;
   logic [OSR_W-1:0] osr;
   logic [OSR_W-1:0] next_osr;
   wire next_sel_ser = settle(s2[SYNC_SEL], s3[SYNC_SEL], sel_ser);
   wire next_cs_n = settle(s2[SYNC_CS], s3[SYNC_CS], cs_n);
   wire next_rd_n = settle(s2[SYNC_RD], s3[SYNC_RD], rd_n);

   always_comb begin
      next_osr = osr;
      for (int i = 0; i < OSR_W; i++) begin
         next_osr[i] = settle(s2[SYNC_OSR+i], s3[SYNC_OSR+i], osr[i]);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         sel_ser <= 1'b0;
         cs_n <= 1'b1;
         rd_n <= 1'b1;
         osr <= '0;
      end else begin
         sel_ser <= next_sel_ser;
         cs_n <= next_cs_n;
         rd_n <= next_rd_n;
         osr <= next_osr;
      end
   end

   // ratio only passes through; the filter that uses it sits elsewhere
   assign oversample_ratio_o = osr;

   ////////////////////////////////////////////////////////////
   // edge detection on settled levels
   logic ser_q;
   logic cs_q;
   logic rd_q;

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         ser_q <= 1'b0;
         cs_q <= 1'b1;
         rd_q <= 1'b1;
      end else begin
         ser_q <= sel_ser;
         cs_q <= cs_n;
         rd_q <= rd_n;
      end
   end

   wire cs_fall = cs_q & ~cs_n;
   wire rd_rise = ~rd_q & rd_n;
   // any mode switch restarts at channel zero, first phase
   wire mode_change = ser_q != sel_ser;

   ////////////////////////////////////////////////////////////
   // channel and phase tracking
   logic [CH_W-1:0] chan;
   logic second;
   logic [BITPOS_W-1:0] bitpos;
   wire par_read = ~sel_ser & ~cs_n & ~rd_n;
   wire par_done = ~sel_ser & ~cs_n & rd_rise;
   wire ser_shift = sel_ser & ~cs_n & rd_rise;
   wire frame_start = sel_ser & cs_fall;
   // a new frame wins over the end of the old one
   wire ser_frame_end = ser_shift & (bitpos == SER_LAST_BIT) & ~frame_start;
   wire chan_step = (par_done & second) | ser_frame_end;
   wire [CH_W-1:0] chan_up = chan_after(chan);
   // second pin runs half the channel count ahead of the first
   wire [CH_W-1:0] chan_b = chan + CH_W'(NUM_CH / 2);

   // strobe count within one channel
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i || mode_change) begin
         second <= 1'b0;
      end else if (par_done) begin
         second <= ~second;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i || mode_change) begin
         chan <= '0;
      end else if (chan_step) begin
         chan <= chan_up;
      end
   end

   // bit position within a serial frame
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i || mode_change) begin
         bitpos <= '0;
      end else if (frame_start || ser_frame_end) begin
         bitpos <= '0;
      end else if (ser_shift) begin
         bitpos <= bitpos + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////
   // data selection; results pass through untouched, already twos complement
   wire [RESULT_W-1:0] res_a = ch_result(results_i, chan);
   wire [RESULT_W-1:0] res_b = ch_result(results_i, chan_b);
   wire [BUS_W-1:0] par_first = res_a[RESULT_W-1:LOW_BITS];
   wire [BUS_W-1:0] par_second = {res_a[LOW_BITS-1:0], {(BUS_W-LOW_BITS){1'b0}}};
   wire [BUS_W-1:0] par_word = second ? par_second : par_first;
   // serial halves: first pin walks channels up from 0, second runs four channels ahead, both wrap after 7, each msb first
   wire ser_first = ser_bit(res_a, bitpos);
   wire ser_second = ser_bit(res_b, bitpos);
   logic [BUS_W-1:0] next_bus;

   always_comb begin
      next_bus = '0;
      if (sel_ser) begin
         next_bus[SER_PIN_FIRST] = ser_first;
         next_bus[SER_PIN_SECOND] = ser_second;
      end else begin
         next_bus = par_word;
      end
   end

   ////////////////////////////////////////////////////////////
   // drive enables
   // spare pins are grounded by the board in serial mode, so never drive them
   wire [BUS_W-1:0] ser_oe_n = cs_n ? BUS_ALL_OFF : SER_PINS_ON;
   wire [BUS_W-1:0] par_oe_n = par_read ? BUS_ALL_ON : BUS_ALL_OFF;
   wire [BUS_W-1:0] next_oe_n = sel_ser ? ser_oe_n : par_oe_n;

   // registered data; one cycle lag after the strobe settles
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         bus_o <= BUS_ALL_ON;
      end else begin
         bus_o <= next_bus;
      end
   end

   // the host sees data a few cycles after its strobe edge, not at once
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         bus_oe_n_o <= BUS_ALL_OFF;
      end else begin
         bus_oe_n_o <= next_oe_n;
      end
   end
endmodule

// file: host_model.sv
`timescale 1ns/10ps
module host_model
   import readout_pkg::*;
(
   input wire logic interface_select_i, // mode
   input wire logic [BUS_W-1:0] bus_o, // drive
   input wire logic [BUS_W-1:0] bus_oe_n_o, // enable
   output logic [BUS_W-1:0] bus_i // level
);
   // released pins read inverted so stale data never passes; serial boards ground spares
   assign bus_i = (bus_o & ~bus_oe_n_o) | (bus_oe_n_o & (interface_select_i ? '0 : ~bus_o));
endmodule

// file: readout_chk.sv
`timescale 1ns/10ps
module readout_chk
   import readout_pkg::*;
(
   input wire logic sys_clk_i, // clk
   input wire logic resetn_i, // rst
   input wire logic interface_select_i, // mode
   input wire logic cs_n_i, // cs
   input wire logic rd_n_sclk_i, // rd
   input wire logic [BUS_W-1:0] bus_o, // data
   input wire logic [BUS_W-1:0] bus_oe_n_o // oe
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   sequence s_idle; !interface_select_i && (cs_n_i || rd_n_sclk_i); endsequence
   sequence s_rd; !interface_select_i && !cs_n_i && !rd_n_sclk_i; endsequence
   sequence s_ser_on; interface_select_i && !cs_n_i; endsequence
   sequence s_ser; interface_select_i; endsequence
   property p_idle; s_idle [*8] |-> bus_oe_n_o == BUS_ALL_OFF; endproperty
   a_idle: assert property (p_idle) else $error("bus not released");
   property p_read; s_rd [*8] |-> bus_oe_n_o == BUS_ALL_ON; endproperty
   a_read: assert property (p_read) else $error("bus not driven");
   property p_ser; s_ser_on [*8] |-> bus_oe_n_o == SER_PINS_ON; endproperty
   a_ser: assert property (p_ser) else $error("serial pins wrong");
   property p_spare; s_ser [*8] |-> (bus_oe_n_o & SER_PINS_ON) == SER_PINS_ON; endproperty
   a_spare: assert property (p_spare) else $error("spare pin driven");
   property p_spare_data; s_ser [*8] |-> (bus_o & SER_PINS_ON) == BUS_ALL_ON; endproperty
   a_spare_data: assert property (p_spare_data) else $error("spare pin data not zero");
   property p_rst; disable iff (1'b0) !resetn_i |=> bus_oe_n_o == BUS_ALL_OFF && bus_o == BUS_ALL_ON; endproperty
   a_rst: assert property (p_rst) else $error("bus not idle after reset");
endmodule
bind adc_result_readout_port readout_chk chk_u (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
   .interface_select_i(interface_select_i), .cs_n_i(cs_n_i), .rd_n_sclk_i(rd_n_sclk_i), .bus_o(bus_o),
   .bus_oe_n_o(bus_oe_n_o));

// file: readout_pkg.sv
package readout_pkg;
   localparam int RESULT_W = 18;
   localparam int BUS_W = 16;
   localparam int NUM_CH = 8;
   localparam int CH_W = 3;
   localparam int OSR_W = 3;
   localparam int SER_PIN_FIRST = 7;
   localparam int SER_PIN_SECOND = 8;
   localparam logic [BUS_W-1:0] BUS_ALL_OFF = 16'hFFFF;
   localparam logic [BUS_W-1:0] SER_PINS_ON = 16'hFE7F;
   localparam logic [CH_W-1:0] LAST_CH = 3'h7;
   localparam logic [4:0] SER_LAST_BIT = 5'h11;
   localparam int LOW_BITS = RESULT_W - BUS_W;
   localparam int BITPOS_W = 5;
   localparam int SYNC_RD = 0;
   localparam int SYNC_CS = 1;
   localparam int SYNC_SEL = 2;
   localparam int SYNC_OSR = 3;
   localparam int SYNC_W = OSR_W + 3;
   localparam logic [SYNC_W-1:0] SYNC_IDLE = 6'h03;
   localparam logic [BUS_W-1:0] BUS_ALL_ON = 16'h0000;
   typedef logic [RESULT_W-1:0] result_t;
endpackage

// file: tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import readout_pkg::*;
   logic clk = 1'b0;
   logic rst_n;
   logic sel;
   logic cs_n;
   logic rd_n;
   logic [OSR_W-1:0] osr_sel;
   logic [OSR_W-1:0] osr_seen;
   logic [BUS_W-1:0] bi;
   logic [BUS_W-1:0] bo;
   logic [BUS_W-1:0] oe_n;
   logic [143:0] res = {18'h2AAAA, 18'h15555, 18'h3FFFF, 18'h00001, 18'h0A5C3, 18'h35A3C, 18'h20000, 18'h1FFFF};
   int error_cnt = 0;
   int n_compared = 0;
   adc_result_readout_port dut_u (.sys_clk_i(clk), .resetn_i(rst_n), .results_i(res), .oversample_ratio_sel_i(osr_sel),
      .oversample_ratio_o(osr_seen), .interface_select_i(sel), .cs_n_i(cs_n), .rd_n_sclk_i(rd_n), .bus_i(bi),
      .bus_o(bo), .bus_oe_n_o(oe_n));
   host_model host_u (.interface_select_i(sel), .bus_o(bo), .bus_oe_n_o(oe_n), .bus_i(bi));
   initial forever #5 clk = ~clk;
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // reads n strobes from read index first; data looked at while the strobe is low
   task automatic t_par(input int n_reads, input int first);
      for (int i = first; i < first + n_reads; i++) begin
         @(posedge clk) rd_n <= 1'b0;
         repeat (8) @(negedge clk);
         chk("bus", {16'h0000, i % 2 ? {res[i/2%8*18 +: 2], 14'h0} : res[i/2%8*18+2 +: 16]}, {oe_n, bi});
         @(posedge clk) rd_n <= 1'b1;
         repeat (8) @(negedge clk);
         chk("oe_n released", {16'h0000, BUS_ALL_OFF}, {16'h0000, oe_n});
      end
   endtask
   task automatic t_ser();
      for (int n = 0; n < 72; n++) begin
         if (n % 18 == 0) begin
            @(posedge clk) cs_n <= 1'b1;
            repeat (8) @(posedge clk);
            cs_n <= 1'b0;
         end
         repeat (8) @(negedge clk);
         chk("serial", {30'h0, res[n/18*18+17-n%18], res[n/18*18+89-n%18]}, {30'h0, bi[7], bi[8]});
         @(posedge clk) rd_n <= 1'b0;
         repeat (4) @(posedge clk);
         rd_n <= 1'b1;
      end
   endtask
   task automatic t_osr(input logic [OSR_W-1:0] v);
      @(posedge clk) osr_sel <= v;
      repeat (8) @(negedge clk);
      chk("osr", {29'h0, v}, {29'h0, osr_seen});
   endtask
   // mid-run reset must idle the bus and restart at channel zero
   task automatic t_reset();
      @(posedge clk) rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk("reset bus", {BUS_ALL_ON, BUS_ALL_OFF}, {bo, oe_n});
   endtask
   initial begin
      rst_n = 1'b0;
      sel = 1'b0;
      cs_n = 1'b1;
      rd_n = 1'b1;
      osr_sel = 3'h5;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      cs_n <= 1'b0;
      t_osr(3'h5);
      t_osr(3'h2);
      t_par(18, 0);
      t_reset();
      t_par(2, 0);
      @(posedge clk) sel <= 1'b1;
      t_ser();
      results();
   end
endmodule
